// ===== src/bau_defs.svh
// constants for the packed-bcd adder unit: offsets, fields, codes, resets
// assumes a 32-bit apb slave with byte addresses on an 8-bit paddr
`ifndef BAU_DEFS_SVH
`define BAU_DEFS_SVH

// register byte offsets, one aligned word each
`define BAU_ADDR_OPA_LO 8'h00
`define BAU_ADDR_OPA_HI 8'h04
`define BAU_ADDR_OPB_LO 8'h08
`define BAU_ADDR_OPB_HI 8'h0C
`define BAU_ADDR_CTRL 8'h10
`define BAU_ADDR_STATUS 8'h14
`define BAU_ADDR_CMD 8'h18
`define BAU_ADDR_RES_LO 8'h1C
`define BAU_ADDR_RES_HI 8'h20
`define BAU_ADDR_COUNT 8'h24

// control word fields
`define BAU_CTRL_FUNC_MSB 8
`define BAU_CTRL_FUNC_LSB 0
`define BAU_CTRL_ONESHOT 9
`define BAU_CTRL_COND 10

// status word fields
`define BAU_STAT_CARRY 0
`define BAU_STAT_ZERO 1
`define BAU_STAT_FAULT 2

// command word: write one here to clear the carry flag
`define BAU_CMD_CARRY_CLEAR 0

// function codes (decimal 405, 406, 407)
`define BAU_FUNC_DSUM 9'h195
`define BAU_FUNC_SUM_CI 9'h196
`define BAU_FUNC_DSUM_CI 9'h197

// reset values and digit limits
`define BAU_WORD_RST 16'h0000
`define BAU_FUNC_RST 9'h000
`define BAU_COUNT_RST 16'h0000
`define BAU_DIGIT_MAX 4'h9
`define BAU_DIGIT_ADJ 5'h06

`endif

// ===== src/bau_pkg.sv
// types shared by the packed-bcd adder unit
// assumes bau_defs.svh is on the include path
package bau_pkg;

  typedef logic [15:0] bau_word_t;

  // selected operation after decoding the function code
  typedef enum logic [1:0] {
    BAU_OP_NONE,
    BAU_OP_DSUM,
    BAU_OP_SUM_CI,
    BAU_OP_DSUM_CI
  } bau_op_e;

  // whole state of the top module, registered in one process
  typedef struct packed {
    bau_word_t opa_lo;
    bau_word_t opa_hi;
    bau_word_t opb_lo;
    bau_word_t opb_hi;
    bau_word_t res_lo;
    bau_word_t res_hi;
    logic [8:0] func;
    logic one_shot;
    logic cond;
    logic cond_prev;
    logic carry;
    logic zero;
    logic fault;
    logic [15:0] exec_cnt;
    logic [31:0] rdata;
    logic rd_done;
  } bau_state_s;

endpackage : bau_pkg

// ===== src/bau_word_add.sv
// one 4-digit packed-bcd word adder with digit validity check
// assumes purely combinational use inside the adder unit
module bau_word_add
  import bau_pkg::*;
(
  // operands and carry in
  input wire logic [15:0] a_in,
  input wire logic [15:0] b_in,
  input wire logic cin_in,
  // sum, carry out and operand check
  output logic [15:0] sum_out,
  output logic cout_out,
  output logic valid_out
);
`include "bau_defs.svh"

  // a digit is bcd only in 0..9
  function automatic logic digit_ok(input logic [3:0] d);
    return d <= `BAU_DIGIT_MAX;
  endfunction : digit_ok

  // ripple through four digits, low digit first
  always_comb begin
    logic [4:0] t;
    logic c;
    t = 5'h00;
    c = cin_in;
    sum_out = 16'h0000;
    valid_out = 1'b1;
    for (int i = 0; i < 4; i++) begin
      valid_out = valid_out & digit_ok(a_in[4*i +: 4]) &
                  digit_ok(b_in[4*i +: 4]); // RULE15
      t = {1'b0, a_in[4*i +: 4]} + {1'b0, b_in[4*i +: 4]} + {4'h0, c};
      // decimal adjust once the digit passes nine
      if (t > {1'b0, `BAU_DIGIT_MAX}) begin
        t = t + `BAU_DIGIT_ADJ;
        c = 1'b1;
      end else begin
        c = 1'b0;
      end
      sum_out[4*i +: 4] = t[3:0];
    end
    cout_out = c;
  end

endmodule : bau_word_add

// ===== src/bau_adder_unit.sv
// packed-bcd adder unit: operands, result and flags behind an apb slave
// assumes apb3 signalling on clock_in, synchronous active-high reset,
// and a sequencer that loads operands and raises the condition bit
//
// Behaviour
// (RULE1) double add without carry-in, eight digits
// (RULE2) low four digits in lower word
// (RULE3) single word add plus carry flag
// (RULE4) double word add plus carry flag
// (RULE5) fault when any source digit invalid
// (RULE6) single add: zero when word is 0000
// (RULE7) double add: zero when both words zero
// (RULE8) carry flag reports carry out of top
// (RULE9) sequencer clears carry when no carry-in
// (RULE10) normal form adds every condition-true cycle
// (RULE11) one-shot adds on condition rising edge
// (RULE12) no falling-edge execution variant
// (RULE13) code 406 single, 407 double, carry-in
// (RULE14) code 405 double without carry-in
// (RULE15) digit valid only in range 0..9
// (RULE16) on fault keep result, carry, zero
//
// Implementation choices: the APB slave port and the register offsets.
module bau_adder_unit
  import bau_pkg::*;
(
  // clock, reset, enable
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // condition flags for the cpu
  output logic carry_flag_out,
  output logic zero_flag_out,
  output logic fault_flag_out
);
`include "bau_defs.svh"

  bau_state_s cur_r;
  bau_state_s cur_nxt;

  // decoded operation and execution strobe
  bau_op_e op;
  logic fire;
  logic dbl;
  logic carry_in;

  // adder results
  logic [15:0] sum_lo;
  logic [15:0] sum_hi;
  logic cout_lo;
  logic cout_hi;
  logic valid_lo;
  logic valid_hi;
  logic ops_valid;

  // bus decode
  logic access;
  logic wr_take;
  logic rd_take;
  logic mapped;

  // map a function code onto an operation
  function automatic bau_op_e decode_op(input logic [8:0] code);
    bau_op_e r;
    r = BAU_OP_NONE;
    if (code == `BAU_FUNC_DSUM) begin
      r = BAU_OP_DSUM; // RULE14
    end else if (code == `BAU_FUNC_SUM_CI) begin
      r = BAU_OP_SUM_CI; // RULE13
    end else if (code == `BAU_FUNC_DSUM_CI) begin
      r = BAU_OP_DSUM_CI; // RULE13
    end
    return r;
  endfunction : decode_op

  // true for every offset that holds a register
  function automatic logic addr_mapped(input logic [7:0] a);
    logic r;
    r = 1'b0;
    unique case (a)
      `BAU_ADDR_OPA_LO, `BAU_ADDR_OPA_HI,
      `BAU_ADDR_OPB_LO, `BAU_ADDR_OPB_HI,
      `BAU_ADDR_CTRL, `BAU_ADDR_STATUS,
      `BAU_ADDR_CMD, `BAU_ADDR_RES_LO,
      `BAU_ADDR_RES_HI, `BAU_ADDR_COUNT: begin
        r = 1'b1;
      end
      default: begin
        r = 1'b0;
      end
    endcase
    return r;
  endfunction : addr_mapped

  // read view of a register; unmapped and command read as zero
  function automatic logic [31:0] read_word(input bau_state_s s,
                                            input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      `BAU_ADDR_OPA_LO: begin
        r = {16'h0000, s.opa_lo};
      end
      `BAU_ADDR_OPA_HI: begin
        r = {16'h0000, s.opa_hi};
      end
      `BAU_ADDR_OPB_LO: begin
        r = {16'h0000, s.opb_lo};
      end
      `BAU_ADDR_OPB_HI: begin
        r = {16'h0000, s.opb_hi};
      end
      `BAU_ADDR_CTRL: begin
        r[`BAU_CTRL_FUNC_MSB:`BAU_CTRL_FUNC_LSB] = s.func;
        r[`BAU_CTRL_ONESHOT] = s.one_shot;
        r[`BAU_CTRL_COND] = s.cond;
      end
      `BAU_ADDR_STATUS: begin
        r[`BAU_STAT_CARRY] = s.carry;
        r[`BAU_STAT_ZERO] = s.zero;
        r[`BAU_STAT_FAULT] = s.fault;
      end
      `BAU_ADDR_RES_LO: begin
        r = {16'h0000, s.res_lo};
      end
      `BAU_ADDR_RES_HI: begin
        r = {16'h0000, s.res_hi};
      end
      `BAU_ADDR_COUNT: begin
        r = {16'h0000, s.exec_cnt};
      end
      default: begin
        r = 32'h0000_0000;
      end
    endcase
    return r;
  endfunction : read_word

  // low-order digits come from the lower word
  bau_word_add u_add_lo (
    .a_in(cur_r.opa_lo), // RULE2
    .b_in(cur_r.opb_lo),
    .cin_in(carry_in),
    .sum_out(sum_lo),
    .cout_out(cout_lo),
    .valid_out(valid_lo)
  );

  // high-order digits, fed by the low word's carry
  bau_word_add u_add_hi (
    .a_in(cur_r.opa_hi), // RULE2
    .b_in(cur_r.opb_hi),
    .cin_in(cout_lo),
    .sum_out(sum_hi),
    .cout_out(cout_hi),
    .valid_out(valid_hi)
  );

  // operation select and execution timing
  always_comb begin
    op = decode_op(cur_r.func);
    dbl = (op == BAU_OP_DSUM) || (op == BAU_OP_DSUM_CI);
    // no carry-in for the plain double add
    carry_in = (op == BAU_OP_DSUM) ? 1'b0 : cur_r.carry; // RULE1 RULE3 RULE4
    // single add checks only the words it reads
    ops_valid = dbl ? (valid_lo & valid_hi) : valid_lo; // RULE5
    // only level and rising edge exist, never a falling edge
    fire = cur_r.cond && (op != BAU_OP_NONE) &&
           (!cur_r.one_shot || !cur_r.cond_prev); // RULE10 RULE11 RULE12
  end

  // apb handshake; reads take one extra cycle so prdata is registered
  always_comb begin
    access = psel_in & penable_in;
    mapped = addr_mapped(paddr_in);
    wr_take = access & pwrite_in & ce_in;
    rd_take = access & ~pwrite_in & ~cur_r.rd_done & ce_in;
    pready_out = access & ce_in & (pwrite_in | cur_r.rd_done);
    pslverr_out = pready_out & ~mapped;
  end

  // next-state: bus writes first, then the execution, which wins
  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.cond_prev = cur_r.cond;

    // read data capture and completion
    if (rd_take) begin
      cur_nxt.rdata = read_word(cur_r, paddr_in);
      cur_nxt.rd_done = 1'b1;
    end else if (cur_r.rd_done && access) begin
      cur_nxt.rd_done = 1'b0;
    end

    // register writes; read-only and unmapped offsets are ignored
    if (wr_take) begin
      unique case (paddr_in)
        `BAU_ADDR_OPA_LO: begin
          cur_nxt.opa_lo = pwdata_in[15:0];
        end
        `BAU_ADDR_OPA_HI: begin
          cur_nxt.opa_hi = pwdata_in[15:0];
        end
        `BAU_ADDR_OPB_LO: begin
          cur_nxt.opb_lo = pwdata_in[15:0];
        end
        `BAU_ADDR_OPB_HI: begin
          cur_nxt.opb_hi = pwdata_in[15:0];
        end
        `BAU_ADDR_CTRL: begin
          cur_nxt.func = pwdata_in[`BAU_CTRL_FUNC_MSB:`BAU_CTRL_FUNC_LSB];
          cur_nxt.one_shot = pwdata_in[`BAU_CTRL_ONESHOT];
          cur_nxt.cond = pwdata_in[`BAU_CTRL_COND];
        end
        `BAU_ADDR_CMD: begin
          // carry stays put between adds until software clears it here
          if (pwdata_in[`BAU_CMD_CARRY_CLEAR]) begin
            cur_nxt.carry = 1'b0; // RULE9
          end
        end
        default: begin
          cur_nxt.rdata = cur_nxt.rdata;
        end
      endcase
    end

    // execution; a carry produced here beats a same-cycle clear
    if (fire) begin
      if (!ops_valid) begin
        cur_nxt.fault = 1'b1; // RULE5
        // destination, carry and zero left as they were
        cur_nxt.carry = cur_nxt.carry; // RULE16
      end else begin
        cur_nxt.fault = 1'b0; // RULE5
        cur_nxt.res_lo = sum_lo; // RULE3
        cur_nxt.exec_cnt = cur_r.exec_cnt + 16'h0001;
        if (dbl) begin
          cur_nxt.res_hi = sum_hi; // RULE1 RULE4
          cur_nxt.carry = cout_hi; // RULE8
          cur_nxt.zero = (sum_lo == 16'h0000) &&
                         (sum_hi == 16'h0000); // RULE7
        end else begin
          cur_nxt.carry = cout_lo; // RULE8
          cur_nxt.zero = (sum_lo == 16'h0000); // RULE6
        end
      end
    end
  end

  // single state register; enable low freezes everything but reset
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cur_r <= '0;
    end else if (ce_in) begin
      cur_r <= cur_nxt;
    end
  end

  // outputs straight from the state register
  assign prdata_out = cur_r.rdata;
  assign carry_flag_out = cur_r.carry;
  assign zero_flag_out = cur_r.zero;
  assign fault_flag_out = cur_r.fault;

endmodule : bau_adder_unit

// ===== sim/bau_adder_unit_props.sv
// port checker for the bcd adder unit: bus answers and flag holding
// assumes one clock domain and a synchronous active-high reset
`include "bau_defs.svh"
module bau_adder_unit_props (
  // clock, reset, enable
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // apb
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // flags
  input wire logic carry_flag_out,
  input wire logic zero_flag_out,
  input wire logic fault_flag_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // enabled access phase
  logic acc;
  assign acc = psel_in && penable_in && ce_in;
  sequence rd_setup; psel_in && !penable_in && !pwrite_in; endsequence
  sequence rd_first; acc && !pwrite_in; endsequence
  wr_ready_a: assert property (acc && pwrite_in |-> pready_out)
    else $error("write not answered");
  ce_hold_a: assert property (!ce_in |-> !pready_out)
    else $error("answer while disabled");
  rd_wait_a: assert property (rd_setup ##1 rd_first |->
    !pready_out ##1 (!ce_in || pready_out)) else $error("read wait wrong");
  err_map_a: assert property (acc && pwrite_in &&
    paddr_in > `BAU_ADDR_COUNT |-> pslverr_out) else $error("no refusal");
  err_gate_a: assert property (pslverr_out |-> acc && pready_out)
    else $error("stray error");
  rd_zero_a: assert property (pslverr_out && !pwrite_in |->
    prdata_out == 32'h0000_0000) else $error("refused read not zero");
  // sampled one edge late, so a capture never trips this early
  rdata_hold_a: assert property (!(acc && !pwrite_in) |=>
    $stable(prdata_out)) else $error("read data moved");
  flag_freeze_a: assert property (!ce_in |=> $stable({carry_flag_out,
    zero_flag_out, fault_flag_out})) else $error("flags moved while off");
  fault_keep_a: assert property ($rose(fault_flag_out) |->
    $stable(zero_flag_out) && !$rose(carry_flag_out))
    else $error("flags changed by fault");
  reset_clear_a: assert property (disable iff (1'b0) rst_in && ce_in |=>
    !carry_flag_out && !zero_flag_out && !fault_flag_out)
    else $error("reset left flags set");
endmodule : bau_adder_unit_props

// ===== sim/bau_seq_model.sv
// sequencer model: apb master loading operands and control words
// assumes the adder unit answers with pready on clock_in
`include "bau_defs.svh"
module bau_seq_model (
  // clock
  input wire logic clock_in,
  // answer from the unit
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  // request to the unit
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [7:0] paddr_out,
  output logic [31:0] pwdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus from time zero
  initial {psel_out, penable_out, pwrite_out, paddr_out, pwdata_out} = 43'h0;
  // one transfer; the leading idle edge keeps back-to-back calls from
  // driving a signal twice in one step
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    logic r;
    @(posedge clock_in);
    {psel_out, pwrite_out, paddr_out, pwdata_out} <= {1'b1, w, a, d};
    @(posedge clock_in);
    penable_out <= 1'b1;
    // answer taken at the rising edge that ends each access cycle
    do begin
      @(posedge clock_in);
      r = pready_in;
      q = prdata_in;
      e = pslverr_in;
    end while (!r);
    {psel_out, penable_out} <= 2'b00;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q,
      output logic e);
    xfer(1'b0, a, 32'h0000_0000, q, e);
  endtask : rd
  // carry clear before an add that wants no carry-in
  task automatic clc();
    wr(`BAU_ADDR_CMD, 32'h0000_0001);
  endtask : clc
endmodule : bau_seq_model

// ===== sim/bau_adder_unit_tb.sv
// self-checking bench for the bcd adder unit: corner and random adds
// assumes bau_seq_model drives the bus and the checker is bound below
`include "bau_defs.svh"
module bau_adder_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic psel_in, penable_in, pwrite_in, e, pready_out, pslverr_out;
  logic carry_flag_out, zero_flag_out, fault_flag_out;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, q;
  int fail_count = 0;
  int n_compared = 0;
  // reference state: result words, flags, execution count
  logic [31:0] m_res = 32'h0000_0000;
  bit m_c, m_z, m_f;
  int m_n = 0;
  // corner cases: codes 405..407 and one unknown
  logic [8:0] tf [6] = '{9'h195, 9'h196, 9'h197, 9'h196, 9'h194, 9'h196};
  bit to [6] = '{1, 1, 0, 1, 1, 1};
  logic [31:0] ta [6] = '{32'h9999_9999, 32'h0000_9999, 32'h1234_5678,
    32'h0000_00A0, 32'h0000_0000, 32'hFFFF_0001};
  logic [31:0] tv [6] = '{32'h0000_0001, 32'h0000_0000, 32'h8765_4320,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0002};
  bau_adder_unit bau_adder_unit_inst (.clock_in(clock_in), .rst_in(rst_in),
    .ce_in(ce_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .carry_flag_out(carry_flag_out),
    .zero_flag_out(zero_flag_out), .fault_flag_out(fault_flag_out));
  bau_seq_model bau_seq_model_inst (.clock_in(clock_in),
    .prdata_in(prdata_out), .pready_in(pready_out),
    .pslverr_in(pslverr_out), .psel_out(psel_in), .penable_out(penable_in),
    .pwrite_out(pwrite_in), .paddr_out(paddr_in), .pwdata_out(pwdata_in));
  // 10 MHz clock
  always #50 clock_in = ~clock_in;
  // packed bcd to integer and back
  function automatic int dec(input logic [31:0] v);
    int r = 0;
    for (int i = 7; i >= 0; i--) r = r * 10 + int'(v[i*4+:4]);
    return r;
  endfunction : dec
  function automatic logic [31:0] bcd(input int v);
    logic [31:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i*4+:4] = 4'(v % 10);
      v = v / 10;
    end
    return r;
  endfunction : bcd
  function automatic bit ok(input logic [31:0] v);
    for (int i = 0; i < 8; i++) if (v[i*4+:4] > 4'h9) return 0;
    return 1;
  endfunction : ok
  // random bcd word, optionally with one bad digit
  function automatic logic [15:0] rw(input bit bad);
    logic [15:0] r;
    for (int i = 0; i < 4; i++) r[i*4+:4] = 4'($urandom % 10);
    if (bad) r[($urandom % 4)*4+:4] = 4'hB;
    return r;
  endfunction : rw
  task automatic chk(input logic [31:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // one execution of the reference; single adds read low words only
  task automatic mstep(input logic [8:0] f, input logic [31:0] a, b);
    bit dbl;
    int s, lim;
    logic [31:0] r;
    dbl = (f != 9'h196);
    if (!dbl) {a[31:16], b[31:16]} = 32'h0000_0000;
    lim = dbl ? 100000000 : 10000;
    if (f < 9'h195 || f > 9'h197) return;
    if (!ok(a) || !ok(b)) begin
      m_f = 1;
      return;
    end
    s = dec(a) + dec(b) + ((f == 9'h195) ? 0 : int'(m_c));
    m_c = (s >= lim);
    r = bcd(s % lim);
    if (dbl) m_res = r; else m_res[15:0] = r[15:0];
    m_z = (s % lim == 0);
    m_f = 0;
    m_n++;
  endtask : mstep
  // load operands, hold the condition, drop it, then compare everything
  task automatic run(input logic [8:0] f, input bit os,
      input logic [31:0] a, b);
    longint t0;
    logic [31:0] v [4];
    v = '{{16'h0, a[15:0]}, {16'h0, a[31:16]}, {16'h0, b[15:0]},
      {16'h0, b[31:16]}};
    for (int k = 0; k < 4; k++) bau_seq_model_inst.wr(8'(4 * k), v[k]);
    bau_seq_model_inst.wr(`BAU_ADDR_CTRL, {21'h0, 1'b1, os, f});
    t0 = $time;
    // enable toggling only in one-shot, where it cannot change the count
    repeat (2 + $urandom % 4) begin
      if (os) ce_in <= 1'($urandom % 2);
      @(posedge clock_in);
    end
    ce_in <= 1'b1;
    bau_seq_model_inst.wr(`BAU_ADDR_CTRL, {21'h0, 1'b0, os, f});
    repeat (os ? 1 : int'(($time - t0) / 100)) mstep(f, a, b);
    bau_seq_model_inst.rd(`BAU_ADDR_STATUS, q, e);
    chk(q, {29'h0, m_f, m_z, m_c}, "status");
    chk({29'h0, fault_flag_out, zero_flag_out, carry_flag_out},
      {29'h0, m_f, m_z, m_c}, "flag pins");
    bau_seq_model_inst.rd(`BAU_ADDR_RES_LO, q, e);
    chk(q, {16'h0, m_res[15:0]}, "low word");
    bau_seq_model_inst.rd(`BAU_ADDR_RES_HI, q, e);
    chk(q, {16'h0, m_res[31:16]}, "high word");
    bau_seq_model_inst.rd(`BAU_ADDR_COUNT, q, e);
    chk(q, {16'h0, 16'(m_n)}, "count");
    $display("test done: func %h one-shot %0d", f, os);
  endtask : run
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // main sequence
  initial begin
    void'($urandom(581));
    repeat (5) @(posedge clock_in);
    rst_in <= 1'b0;
    bau_seq_model_inst.rd(`BAU_ADDR_COUNT, q, e);
    chk({q[30:0], e}, 32'h0000_0000, "count after reset");
    bau_seq_model_inst.wr(`BAU_ADDR_STATUS, 32'h0000_0007);
    bau_seq_model_inst.wr(8'h40, 32'hFFFF_FFFF);
    bau_seq_model_inst.rd(8'h40, q, e);
    chk({q[30:0], e}, 32'h0000_0001, "unmapped read");
    $display("test done: bus map and reset values");
    for (int i = 0; i < 6; i++) run(tf[i], to[i], ta[i], tv[i]);
    for (int i = 0; i < 24; i++) begin
      if ($urandom % 2) begin
        bau_seq_model_inst.clc();
        m_c = 0;
      end
      run(9'(9'h195 + $urandom % 3), 1'($urandom % 2),
        {rw(0), rw($urandom % 6 == 0)}, {rw(0), rw(0)});
    end
    end_sim();
  end
  // hang guard: the tests need a few thousand cycles at most
  initial begin
    #2000000;
    fail_count++;
    end_sim();
  end
endmodule : bau_adder_unit_tb

bind bau_adder_unit bau_adder_unit_props bau_adder_unit_props_inst (
  .clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .carry_flag_out(carry_flag_out),
  .zero_flag_out(zero_flag_out), .fault_flag_out(fault_flag_out));
